//--- dv/acc_cmp_model.sv
// Behavioural model of the four analog comparators and their reference DACs
module acc_cmp_model (
	input  wire logic [39:0] reference_code,
	input  wire logic [3:0]  comparator_power,
	input  wire logic [39:0] pin_level,
	input  wire logic [3:0]  spike,
	output logic      [3:0]  comparator_raw
);
	// ****************************************
	// Comparison of pin level against DAC level
	// ****************************************
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			// Unpowered comparator reads low
			comparator_raw[i] = comparator_power[i]
				&& ((pin_level[10 * i +: 10] > reference_code[10 * i +: 10]) ^ spike[i]);
		end
	end
endmodule : acc_cmp_model

//--- dv/testbench.sv
// Self-checking bench for the comparator bank control block
`include "acc_defines.svh"

module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************
	// Signals and instances
	// ****************************************
	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, idle_mode = 1'b0, sleep_mode = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic [39:0] pin_level = 40'h0, reference_code;
	logic [3:0]  spike = 4'h0, comparator_raw, comparator_power, external_reference_select;
	logic [3:0]  dac_range_high, adc_trigger, output_state;
	logic [7:0]  input_source_select;
	logic        hreadyout, hresp, irq, wake_req, trig_q = 1'b0;
	int          err_count = 0, cmp_count = 0, cycles = 0, trig_cnt = 0;

	always #5 hclk = ~hclk;

	acc_top i_acc_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .comparator_raw(comparator_raw), .idle_mode(idle_mode),
		.sleep_mode(sleep_mode), .comparator_power(comparator_power), .input_source_select(input_source_select),
		.external_reference_select(external_reference_select), .dac_range_high(dac_range_high),
		.reference_code(reference_code), .adc_trigger(adc_trigger), .output_state(output_state),
		.irq(irq), .wake_req(wake_req));
	acc_cmp_model i_acc_cmp_model (.reference_code(reference_code), .comparator_power(comparator_power),
		.pin_level(pin_level), .spike(spike), .comparator_raw(comparator_raw));

	// ****************************************
	// Tasks
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : chk

	task automatic xfer(input logic wr_en, input logic [13:0] idx, input logic [31:0] wd);
		haddr  <= {16'h0000, idx, 2'b00};
		htrans <= 2'b10;
		hwrite <= wr_en;
		hsel   <= 1'b1;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		htrans <= 2'b00;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		rd = hrdata;
	endtask : xfer

	task automatic wr(input logic [13:0] idx, input logic [31:0] wd);
		xfer(1'b1, idx, wd);
	endtask : wr

	task automatic rdc(input logic [13:0] idx, input logic [31:0] exp, input string msg);
		xfer(1'b0, idx, 32'h0);
		chk(rd, exp, msg);
	endtask : rdc

	task automatic tick(input int n);
		repeat (n) @(posedge hclk);
	endtask : tick

	task automatic give_verdict();
		$display("TB: %0d compares, %0d mismatches", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : give_verdict

	// Trigger pulse counter, width watch and timeout
	always @(posedge hclk) begin
		cycles <= cycles + 1;
		trig_q <= adc_trigger[0];
		if (adc_trigger[0] === 1'b1)
			trig_cnt <= trig_cnt + 1;
		if (adc_trigger[0] === 1'b1 && trig_q === 1'b1) begin
			err_count++;
			$display("ERROR %0t: trigger wider than one cycle", $time);
		end
		if (cycles == 20000) begin
			err_count++;
			$display("ERROR %0t: timeout", $time);
			give_verdict();
		end
	end

	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int i = 0; i < 8; i++)
			rdc(`ACC_IDX_CTL1 + 14'(2 * i), 32'h0, "reset value");
		rdc(14'h0500, 32'h0, "unmapped");
		chk(hresp, 1'b0, "okay response");
		chk(hreadyout, 1'b1, "zero wait states");
		$display("TB: reset test done");
		for (int i = 0; i < 4; i++) begin
			wr(`ACC_IDX_CTL1 + 14'(4 * i), 32'h5f3d | 32'(i << 6));
			rdc(`ACC_IDX_CTL1 + 14'(4 * i), 32'h0021 | 32'(i << 6), "ctl fields");
			chk(input_source_select[2 * i +: 2], 32'(i), "source select");
			chk(external_reference_select[i], 1'b1, "ext ref");
			chk(dac_range_high[i], 1'b1, "range");
			wr(`ACC_IDX_CTL1 + 14'(4 * i), 32'h7fff);
			rdc(`ACC_IDX_CTL1 + 14'(4 * i), 32'h20e3, "ctl ones");
			wr(`ACC_IDX_CTL1 + 14'(4 * i), 32'h0);
			wr(`ACC_IDX_DAC1 + 14'(4 * i), 32'hffff - 32'(i));
			rdc(`ACC_IDX_DAC1 + 14'(4 * i), 32'h03ff - 32'(i), "dac level");
			chk(reference_code[10 * i +: 10], 32'h03ff - 32'(i), "ref code");
			chk(external_reference_select[i], 1'b0, "int ref");
			chk(dac_range_high[i], 1'b0, "low range");
		end
		$display("TB: field test done");
		wr(`ACC_IDX_DAC1, 32'h100);
		wr(`ACC_IDX_CTL1, 32'h8000);
		tick(2);
		chk(comparator_power, 4'h1, "power on");
		spike <= 4'h1;
		tick(1);
		spike <= 4'h0;
		tick(12);
		chk(output_state[0], 1'b0, "glitch state");
		chk(trig_cnt, 0, "glitch trigger");
		pin_level[9:0] <= 10'h200;
		tick(12);
		chk(output_state[0], 1'b1, "state high");
		rdc(`ACC_IDX_CTL1, 32'h8008, "state bit");
		chk(trig_cnt, 1, "one trigger");
		chk(irq, 1'b0, "masked irq");
		rdc(`ACC_IDX_ISTAT, 32'h1, "status set");
		wr(`ACC_IDX_IEN, 32'h1);
		tick(2);
		chk(irq, 1'b1, "irq on");
		wr(`ACC_IDX_ICLR, 32'h1);
		tick(2);
		chk(irq, 1'b0, "irq cleared");
		rdc(`ACC_IDX_ISTAT, 32'h0, "status clear");
		rdc(`ACC_IDX_ICLR, 32'h0, "clear reads zero");
		$display("TB: event test done");
		wr(`ACC_IDX_CTL1, 32'h8002);
		tick(12);
		chk(output_state[0], 1'b0, "inverted");
		chk(trig_cnt, 1, "no trigger on fall");
		wr(`ACC_IDX_CTL1, 32'h8000);
		tick(12);
		chk(trig_cnt, 2, "trigger on rise");
		chk(irq, 1'b1, "irq again");
		wr(`ACC_IDX_DAC1, 32'h3ff);
		tick(12);
		chk(output_state[0], 1'b0, "below reference");
		wr(`ACC_IDX_CTL1, 32'h2);
		wr(`ACC_IDX_DAC1, 32'h10);
		tick(12);
		chk(comparator_power, 4'h0, "power off");
		chk(output_state[0], 1'b0, "disabled state");
		chk(trig_cnt, 2, "disabled trigger");
		$display("TB: polarity test done");
		wr(`ACC_IDX_CTL1, 32'h8000);
		wr(`ACC_IDX_CTL2, 32'h2000);
		idle_mode <= 1'b1;
		tick(12);
		chk(comparator_power[0], 1'b0, "group halt");
		wr(`ACC_IDX_CTL2, 32'h0);
		tick(12);
		chk(comparator_power[0], 1'b1, "runs in idle");
		chk(wake_req, 1'b1, "wake in idle");
		wr(`ACC_IDX_CTL1, 32'ha000);
		tick(2);
		chk(comparator_power[0], 1'b0, "own halt");
		idle_mode <= 1'b0;
		sleep_mode <= 1'b1;
		tick(12);
		chk(wake_req, 1'b1, "wake in sleep");
		$display("TB: low power test done");
		give_verdict();
	end
endmodule : testbench

//--- verilog/acc_defines.svh
// Register offsets, field positions, reset values and timing counts of the comparator bank
`ifndef ACC_DEFINES_SVH
`define ACC_DEFINES_SVH

// ***************************************************
// Register indices (byte address is four times the index)
// ***************************************************
`define ACC_IDX_CTL1     14'h04c0
`define ACC_IDX_DAC1     14'h04c2
`define ACC_IDX_CTL2     14'h04c4
`define ACC_IDX_DAC2     14'h04c6
`define ACC_IDX_CTL3     14'h04c8
`define ACC_IDX_DAC3     14'h04ca
`define ACC_IDX_CTL4     14'h04cc
`define ACC_IDX_DAC4     14'h04ce
`define ACC_IDX_ISTAT    14'h04d0
`define ACC_IDX_IEN      14'h04d2
`define ACC_IDX_ICLR     14'h04d4

// ***************************************************
// Field positions
// ***************************************************
`define ACC_BIT_ENABLE   15
`define ACC_BIT_HALTIDLE 13
`define ACC_BIT_INSEL_HI 7
`define ACC_BIT_INSEL_LO 6
`define ACC_BIT_EXTERNAL_REFERENCE_SELECT   5
`define ACC_BIT_STATE    3
`define ACC_BIT_POL      1
`define ACC_BIT_RANGE    0
`define ACC_CTL_WMASK    16'ha0e3
`define ACC_DAC_WMASK    16'h03ff

// ***************************************************
// Reset values and timing
// ***************************************************
`define ACC_CTL_RESET    16'h0000
`define ACC_DAC_RESET    10'h000
`define ACC_FILT_NS      20
`define ACC_CLK_NS       10
`define ACC_FILT_CYC     ((`ACC_FILT_NS + `ACC_CLK_NS - 1) / `ACC_CLK_NS)

`endif

//--- verilog/acc_pkg.sv
// Types shared by the comparator bank control logic
package acc_pkg;

	typedef enum logic [3:0] {
		ACC_SEL_CTL1, ACC_SEL_DAC1, ACC_SEL_CTL2, ACC_SEL_DAC2,
		ACC_SEL_CTL3, ACC_SEL_DAC3, ACC_SEL_CTL4, ACC_SEL_DAC4,
		ACC_SEL_ISTAT, ACC_SEL_IEN, ACC_SEL_ICLR, ACC_SEL_NONE
	} acc_sel_t;

	typedef struct packed {
		logic [3:0][15:0] ctl;
		logic [3:0][9:0]  dac;
		logic [3:0]       sy1;
		logic [3:0]       sy2;
		logic [3:0]       sy3;
		logic [3:0]       agreed;
		logic [3:0]       filt;
		logic [3:0]       fcnt;
		logic [3:0]       prev;
		logic [3:0]       run;
		logic [3:0]       state;
		logic [3:0]       trig;
		logic [3:0]       ists;
		logic [3:0]       ien;
		logic             irq;
		logic             wake;
		logic             dph_wr;
		acc_sel_t         dph_sel;
		logic [31:0]      rdata;
		logic             ready;
	} acc_state_t;

endpackage : acc_pkg

//--- verilog/acc_top.sv
// Control and status logic for a bank of four comparators with reference DACs
//
// Design decision made here: the AHB-Lite slave port.

`include "acc_defines.svh"

module acc_top (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic [3:0]  comparator_raw,
	input  wire logic        idle_mode,
	input  wire logic        sleep_mode,
	output logic [3:0]       comparator_power,
	output logic [7:0]       input_source_select,
	output logic [3:0]       external_reference_select,
	output logic [3:0]       dac_range_high,
	output logic [39:0]      reference_code,
	output logic [3:0]       adc_trigger,
	output logic [3:0]       output_state,
	output logic             irq,
	output logic             wake_req
);

	localparam int FILT_CYC = `ACC_FILT_CYC;

	acc_pkg::acc_state_t s_r;
	acc_pkg::acc_state_t s_nxt;

	// ***************************************************
	// Helpers
	// ***************************************************
	function automatic acc_pkg::acc_sel_t addr_decode(input logic [31:0] a);
		logic [13:0] idx;
		idx = a[15:2];
		if (a[31:16] != 16'h0000) begin
			addr_decode = acc_pkg::ACC_SEL_NONE;
		end else begin
			case (idx)
				`ACC_IDX_CTL1:  addr_decode = acc_pkg::ACC_SEL_CTL1;
				`ACC_IDX_DAC1:  addr_decode = acc_pkg::ACC_SEL_DAC1;
				`ACC_IDX_CTL2:  addr_decode = acc_pkg::ACC_SEL_CTL2;
				`ACC_IDX_DAC2:  addr_decode = acc_pkg::ACC_SEL_DAC2;
				`ACC_IDX_CTL3:  addr_decode = acc_pkg::ACC_SEL_CTL3;
				`ACC_IDX_DAC3:  addr_decode = acc_pkg::ACC_SEL_DAC3;
				`ACC_IDX_CTL4:  addr_decode = acc_pkg::ACC_SEL_CTL4;
				`ACC_IDX_DAC4:  addr_decode = acc_pkg::ACC_SEL_DAC4;
				`ACC_IDX_ISTAT: addr_decode = acc_pkg::ACC_SEL_ISTAT;
				`ACC_IDX_IEN:   addr_decode = acc_pkg::ACC_SEL_IEN;
				`ACC_IDX_ICLR:  addr_decode = acc_pkg::ACC_SEL_ICLR;
				default:        addr_decode = acc_pkg::ACC_SEL_NONE;
			endcase
		end
	endfunction : addr_decode

	// Control word as software sees it: stored fields plus live output state
	function automatic logic [15:0] ctl_view(input logic [15:0] c, input logic st);
		ctl_view = (c & `ACC_CTL_WMASK) | ({15'h0000, st} << `ACC_BIT_STATE);
	endfunction : ctl_view

	// ***************************************************
	// Next-state logic
	// ***************************************************
	always_comb begin
		logic                 take;
		logic                 halt_all;
		logic                 low_power;
		logic                 src;
		logic [3:0]           clr;
		logic [3:0]           set;
		logic [1:0]           ci;
		acc_pkg::acc_sel_t    sel;
		take      = 1'b0;
		halt_all  = 1'b0;
		low_power = idle_mode | sleep_mode;
		src       = 1'b0;
		clr       = 4'h0;
		set       = 4'h0;
		ci        = 2'h0;
		sel       = acc_pkg::ACC_SEL_NONE;
		s_nxt     = s_r;
		s_nxt.ready = 1'b1;

		// Data phase of a write: stored at the end of the phase
		if (s_r.dph_wr) begin
			case (s_r.dph_sel)
				acc_pkg::ACC_SEL_CTL1: s_nxt.ctl[0] = hwdata[15:0] & `ACC_CTL_WMASK;
				acc_pkg::ACC_SEL_CTL2: s_nxt.ctl[1] = hwdata[15:0] & `ACC_CTL_WMASK;
				acc_pkg::ACC_SEL_CTL3: s_nxt.ctl[2] = hwdata[15:0] & `ACC_CTL_WMASK;
				acc_pkg::ACC_SEL_CTL4: s_nxt.ctl[3] = hwdata[15:0] & `ACC_CTL_WMASK;
				acc_pkg::ACC_SEL_DAC1: s_nxt.dac[0] = hwdata[9:0];
				acc_pkg::ACC_SEL_DAC2: s_nxt.dac[1] = hwdata[9:0];
				acc_pkg::ACC_SEL_DAC3: s_nxt.dac[2] = hwdata[9:0];
				acc_pkg::ACC_SEL_DAC4: s_nxt.dac[3] = hwdata[9:0];
				acc_pkg::ACC_SEL_IEN:  s_nxt.ien    = hwdata[3:0];
				acc_pkg::ACC_SEL_ICLR: clr          = hwdata[3:0];
				default: begin
				end
			endcase
		end

		// Any halt-in-idle bit halts the whole bank while Idle lasts
		for (int i = 0; i < 4; i++) begin
			halt_all = halt_all | s_r.ctl[i][`ACC_BIT_HALTIDLE];
		end
		halt_all = halt_all & idle_mode;

		for (int i = 0; i < 4; i++) begin
			s_nxt.run[i] = s_nxt.ctl[i][`ACC_BIT_ENABLE] & ~halt_all;
			s_nxt.sy1[i] = comparator_raw[i];
			s_nxt.sy2[i] = s_r.sy1[i];
			s_nxt.sy3[i] = s_r.sy2[i];
			if (s_r.sy2[i] == s_r.sy3[i]) begin
				s_nxt.agreed[i] = s_r.sy3[i];
			end
			if (!s_r.run[i]) begin
				s_nxt.filt[i]  = 1'b0;
				s_nxt.fcnt[i]  = 1'b0;
				s_nxt.prev[i]  = 1'b0;
				s_nxt.state[i] = 1'b0;
				s_nxt.trig[i]  = 1'b0;
			end else begin
				// A new level must hold for the filter span before it is taken
				if (s_r.agreed[i] == s_r.filt[i]) begin
					s_nxt.fcnt[i] = 1'b0;
				end else if (s_r.fcnt[i] == 1'(FILT_CYC - 1)) begin
					s_nxt.filt[i] = s_r.agreed[i];
					s_nxt.fcnt[i] = 1'b0;
				end else begin
					s_nxt.fcnt[i] = 1'b1;
				end
				// Low-power modes take the unfiltered level
				src = low_power ? s_r.agreed[i] : s_r.filt[i];
				src = src ^ s_r.ctl[i][`ACC_BIT_POL];
				s_nxt.state[i] = src;
				s_nxt.prev[i]  = src;
				// No pulse in the cycle in which the instance is switched off
				s_nxt.trig[i]  = src & ~s_r.prev[i] & s_nxt.run[i];
				set[i]         = src & ~s_r.prev[i] & s_nxt.run[i];
			end
		end

		// Set wins over a clear in the same cycle
		s_nxt.ists = (s_r.ists & ~clr) | set;
		s_nxt.irq  = |(s_nxt.ists & s_nxt.ien);
		s_nxt.wake = low_power & (|(s_nxt.state & s_nxt.ien & s_nxt.run));

		// Address phase
		take = hsel & hready & htrans[1];
		sel  = addr_decode(haddr);
		s_nxt.dph_wr  = take & hwrite;
		s_nxt.dph_sel = take ? sel : acc_pkg::ACC_SEL_NONE;
		s_nxt.rdata   = 32'h0000_0000;
		if (take && !hwrite) begin
			ci = sel[2:1];
			case (sel)
				acc_pkg::ACC_SEL_CTL1, acc_pkg::ACC_SEL_CTL2,
				acc_pkg::ACC_SEL_CTL3, acc_pkg::ACC_SEL_CTL4:
					s_nxt.rdata = {16'h0000, ctl_view(s_r.ctl[ci], s_r.state[ci])};
				acc_pkg::ACC_SEL_DAC1, acc_pkg::ACC_SEL_DAC2,
				acc_pkg::ACC_SEL_DAC3, acc_pkg::ACC_SEL_DAC4:
					s_nxt.rdata = {22'h000000, s_r.dac[ci]};
				acc_pkg::ACC_SEL_ISTAT:
					s_nxt.rdata = {28'h0000000, s_r.ists};
				acc_pkg::ACC_SEL_IEN:
					s_nxt.rdata = {28'h0000000, s_r.ien};
				default:
					s_nxt.rdata = 32'h0000_0000;
			endcase
		end
	end

	// ***************************************************
	// State register
	// ***************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_r         <= '0;
			s_r.ctl     <= {4{`ACC_CTL_RESET}};
			s_r.dac     <= {4{`ACC_DAC_RESET}};
			s_r.dph_sel <= acc_pkg::ACC_SEL_NONE;
			s_r.ready   <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ***************************************************
	// Outputs
	// ***************************************************
	assign hreadyout = s_r.ready;
	assign hresp     = 1'b0;
	assign hrdata    = s_r.rdata;
	assign irq       = s_r.irq;
	assign wake_req  = s_r.wake;
	assign adc_trigger  = s_r.trig;
	assign output_state = s_r.state;
	assign comparator_power = s_r.run;

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			input_source_select[2*i +: 2] = s_r.ctl[i][`ACC_BIT_INSEL_HI:`ACC_BIT_INSEL_LO];
			external_reference_select[i]  = s_r.ctl[i][`ACC_BIT_EXTERNAL_REFERENCE_SELECT];
			dac_range_high[i]             = s_r.ctl[i][`ACC_BIT_RANGE];
			reference_code[10*i +: 10]    = s_r.dac[i];
		end
	end

	// ***************************************************
	// Checks
	// ***************************************************
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	chk_ctl_reserved: assert property (
		((s_r.ctl[0] | s_r.ctl[1] | s_r.ctl[2] | s_r.ctl[3]) & ~`ACC_CTL_WMASK) == 16'h0000)
		else $error("control reserved bits stored non-zero");

	chk_dac_readback: assert property (
		(hsel && hready && htrans[1] && !hwrite && addr_decode(haddr) == acc_pkg::ACC_SEL_DAC2)
		|=> hrdata[31:10] == 22'h000000 && hrdata[9:0] == $past(s_r.dac[1]))
		else $error("DAC level read back wrong");

	chk_idle_halt: assert property (
		(idle_mode && s_r.ctl[2][`ACC_BIT_HALTIDLE]) |=> comparator_power == 4'h0)
		else $error("bank not halted in idle");

	chk_enable_off: assert property (
		!s_r.ctl[0][`ACC_BIT_ENABLE] |-> !comparator_power[0] && !adc_trigger[0])
		else $error("disabled instance still running");

	chk_pulse_width: assert property (
		adc_trigger[0] |-> s_r.ists[0] ##1 !adc_trigger[0])
		else $error("trigger pulse longer than one cycle");

	chk_pulse_cause: assert property (
		$rose(adc_trigger[0]) |-> $past(comparator_power[0]) && output_state[0] && !$past(output_state[0]))
		else $error("trigger without active-going edge");

	chk_filter_span: assert property (
		(!idle_mode && !sleep_mode && $changed(s_r.filt[0]) && comparator_power[0])
		|-> $past(s_r.agreed[0]) == s_r.filt[0] && $past(s_r.agreed[0], 2) == s_r.filt[0])
		else $error("filter passed a short pulse");

	chk_polarity: assert property (
		(comparator_power[0] && $stable(comparator_power[0]) && !idle_mode && !sleep_mode)
		|=> output_state[0] == ($past(s_r.filt[0]) ^ $past(s_r.ctl[0][`ACC_BIT_POL])))
		else $error("output state not polarity adjusted");

	chk_write_effect: assert property (
		(s_r.dph_wr && s_r.dph_sel == acc_pkg::ACC_SEL_DAC3) |=> reference_code[29:20] == $past(hwdata[9:0]))
		else $error("DAC write not applied at next edge");

	chk_irq_level: assert property (
		(s_r.ists & s_r.ien) != 4'h0 |-> irq)
		else $error("interrupt low with enabled status set");

	chk_irq_quiet: assert property (
		(s_r.ists & s_r.ien) == 4'h0 |-> !irq)
		else $error("interrupt high with no enabled status");

	chk_trig_gated: assert property (
		(adc_trigger & ~comparator_power) == 4'h0)
		else $error("trigger from a powered-down instance");

	chk_pulse_spacing: assert property (
		(adc_trigger & $past(adc_trigger)) == 4'h0)
		else $error("trigger pulses in two cycles in a row");

	chk_clear_effect: assert property (
		(s_r.dph_wr && s_r.dph_sel == acc_pkg::ACC_SEL_ICLR && hwdata[0])
		|=> s_r.ists[0] == adc_trigger[0])
		else $error("status clear lost or beat a new event");

	chk_ists_readonly: assert property (
		(s_r.dph_wr && s_r.dph_sel == acc_pkg::ACC_SEL_ISTAT)
		|=> s_r.ists == ($past(s_r.ists) | adc_trigger))
		else $error("status register changed by a write");

	chk_ien_write: assert property (
		(s_r.dph_wr && s_r.dph_sel == acc_pkg::ACC_SEL_IEN)
		|=> s_r.ien == $past(hwdata[3:0]))
		else $error("interrupt enable write not applied");

	chk_bus_okay: assert property (
		hreadyout && !hresp)
		else $error("bus slave stalled or answered an error");

	chk_rdata_idle: assert property (
		!(hsel && hready && htrans[1] && !hwrite)
		|=> hrdata == 32'h0000_0000)
		else $error("read data driven outside a read data phase");

	chk_ctl_readback: assert property (
		(hsel && hready && htrans[1] && !hwrite && addr_decode(haddr) == acc_pkg::ACC_SEL_CTL1)
		|=> hrdata[31:16] == 16'h0000 && hrdata[14] == 1'b0 && hrdata[12:8] == 5'h00
			&& hrdata[4] == 1'b0 && hrdata[2] == 1'b0 && hrdata[3] == $past(output_state[0]))
		else $error("control read back wrong");

	chk_source_map: assert property (
		(s_r.dph_wr && s_r.dph_sel == acc_pkg::ACC_SEL_CTL4)
		|=> input_source_select[7:6] == $past(hwdata[7:6]))
		else $error("source select not taken from control write");

	chk_reference_map: assert property (
		(s_r.dph_wr && s_r.dph_sel == acc_pkg::ACC_SEL_CTL2)
		|=> external_reference_select[1] == $past(hwdata[`ACC_BIT_EXTERNAL_REFERENCE_SELECT])
			&& dac_range_high[1] == $past(hwdata[`ACC_BIT_RANGE]))
		else $error("reference or range not taken from control write");

	chk_dac_level: assert property (
		(s_r.dph_wr && s_r.dph_sel == acc_pkg::ACC_SEL_DAC1)
		|=> reference_code[9:0] == $past(hwdata[9:0]))
		else $error("reference code not taken from level write");

	chk_run_enable: assert property (
		(s_r.ctl[0][`ACC_BIT_ENABLE] && !idle_mode && !(s_r.dph_wr && s_r.dph_sel == acc_pkg::ACC_SEL_CTL1))
		|=> comparator_power[0])
		else $error("enabled instance not running");

	chk_halt_own: assert property (
		(idle_mode && s_r.ctl[0][`ACC_BIT_HALTIDLE]) |=> !comparator_power[0])
		else $error("instance with halt bit still running in idle");

	chk_state_off: assert property (
		!comparator_power[0] |=> !output_state[0])
		else $error("output state live while powered down");

	chk_sync_agree: assert property (
		$changed(s_r.agreed[0])
		|-> $past(s_r.sy2[0]) == s_r.agreed[0] && $past(s_r.sy3[0]) == s_r.agreed[0])
		else $error("input level taken before two stages agreed");

	chk_filter_take: assert property (
		(s_r.run[0] && s_r.agreed[0] != s_r.filt[0] && $stable(s_r.agreed[0])) [*2]
		|=> s_r.filt[0] == $past(s_r.agreed[0]))
		else $error("filter held a settled level too long");

	chk_bypass_path: assert property (
		((idle_mode || sleep_mode) && comparator_power[0])
		|=> output_state[0] == ($past(s_r.agreed[0]) ^ $past(s_r.ctl[0][`ACC_BIT_POL])))
		else $error("low-power state not taken from the unfiltered level");

	chk_wake_awake: assert property (
		(!idle_mode && !sleep_mode) |=> !wake_req)
		else $error("wake request outside low-power modes");

	cov_trigger:   cover property (adc_trigger[0] ##1 !adc_trigger[0]);
	cov_idle_halt: cover property (idle_mode && s_r.ctl[3][`ACC_BIT_HALTIDLE] ##1 comparator_power == 4'h0);
	cov_wake:      cover property (sleep_mode ##[1:20] wake_req);
	cov_set_clear: cover property (s_r.dph_wr && s_r.dph_sel == acc_pkg::ACC_SEL_ICLR ##1 s_r.ists == 4'h0);
	cov_bypass:    cover property ((idle_mode || sleep_mode) && output_state[0] ##1 wake_req);

endmodule : acc_top
